// file: verilog/trf_report.sv
// Touch reporting block: live status, 30-entry event queue, fault register.
// Assumes the I2C slave decodes each register access into a one-cycle strobe
// with an address, and that the scan engine reports events on this clock.
// How it works
// - Live touch status readable at 0x02.
// - Bit n shows electrode n+1 touched.
// - Live status shows at most one electrode.
// - Queue holds 30 events; extras are lost.
// - Reading 0x00 pops the presented entry.
// - Any write to 0x00 flushes the queue.
// - Reading last entry leaves queue empty.
// - Bit 7 set when more entries remain.
// - Bit 6 set while queue is empty.
// - Bit 5 set after an overflow.
// - Bit 4 is touch, zero is release.
// - Bits 3:0 hold electrode index 0-7.
// - Shorts to supply or ground raise fault.
// - Scanning halts while a short fault stands.
// - Only the first detected short is kept.
// - Fault bit 4 shows touch limit exceeded.
// - Fault bits 1:0 encode the short kind.
// - Fault clears by write only in stop.
// - Fault register at 0x01, otherwise read-only.
// - Data interrupt on empty flag falling edge.
// - Fault interrupt on zero to nonzero code.
// - Stop mode: scan enable low, duty bit high.
`timescale 1ns/1ps
`default_nettype none
module trf_report
  import trf_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port from the I2C slave.
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  output logic [7:0] reg_rdata_o,
  // Mode bits from the configuration logic.
  input wire logic scan_enable_bit_i,
  input wire logic duty_cycle_disable_bit_i,
  input wire logic [3:0] max_touch_count_setting_i,
  // Scan engine results.
  input wire logic [7:0] touched_i,
  input wire logic event_valid_i,
  input wire logic event_touch_i,
  input wire logic [2:0] event_electrode_i,
  input wire logic short_gnd_i,
  input wire logic short_supply_i,
  output logic scan_allow_o,
  // Interrupt trigger outputs toward the interrupt pin logic.
  output logic data_irq_o,
  output logic fault_irq_o
);

  // Decoded strobes.
  logic rd_queue;
  logic wr_queue;
  logic wr_fault;
  logic stop_mode;

  assign rd_queue = reg_rd_i && (reg_addr_i == TRF_ADDR_QUEUE);
  assign wr_queue = reg_wr_i && (reg_addr_i == TRF_ADDR_QUEUE);
  assign wr_fault = reg_wr_i && (reg_addr_i == TRF_ADDR_FAULT);
  // Only in the low-power-off stop mode are fault writes honoured.
  assign stop_mode = !scan_enable_bit_i && duty_cycle_disable_bit_i;

  // Lowest touched electrode isolated so only one bit shows at a time.
  function automatic logic [7:0] lowest_one(input logic [7:0] v);
    lowest_one = v & (~v + 8'h01);
  endfunction

  // Population count for the touch limit check.
  function automatic logic [3:0] pop_count(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < TRF_NUM_ELECTRODES; i++) begin
      n = n + {3'b000, v[i]};
    end
    pop_count = n;
  endfunction

  // Live status register, bit n for electrode n+1.
  logic [7:0] live_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      live_r <= TRF_LIVE_RESET;
    end else begin
      live_r <= lowest_one(touched_i);
    end
  end

  // Touch limit flag follows the live touch count continuously.
  logic limit_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      limit_r <= 1'b0;
    end else begin
      limit_r <= (pop_count(touched_i) > max_touch_count_setting_i);
    end
  end

  // Occupancy counter caps the queue at 30 even though storage holds 32.
  logic [4:0] count_r;
  logic push;
  logic pop;
  logic ovf_r;
  logic full;
  logic [TRF_EVENT_WIDTH-1:0] head_data;
  logic head_valid;
  logic mid_valid;
  logic mid_ready;
  logic [TRF_EVENT_WIDTH-1:0] mid_data;
  logic tail_ready;

  assign full = (count_r == 5'(TRF_QUEUE_DEPTH));
  // The tail stage's ready also stalls acceptance, so back-pressure is honest.
  assign push = event_valid_i && !full && tail_ready && !wr_queue;
  assign pop = rd_queue && head_valid && !wr_queue;

  // Two chained 16-word stages form the event store.
  trf_fifo #(.WIDTH(TRF_EVENT_WIDTH), .DEPTH(TRF_FIFO_DEPTH)) u_tail (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .flush_i(wr_queue),
    .in_valid_i(push),
    .in_ready_o(tail_ready),
    .in_data_i({event_touch_i, 1'b0, event_electrode_i}),
    .out_valid_o(mid_valid),
    .out_ready_i(mid_ready),
    .out_data_o(mid_data)
  );
  trf_fifo #(.WIDTH(TRF_EVENT_WIDTH), .DEPTH(TRF_FIFO_DEPTH)) u_head (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .flush_i(wr_queue),
    .in_valid_i(mid_valid),
    .in_ready_o(mid_ready),
    .in_data_i(mid_data),
    .out_valid_o(head_valid),
    .out_ready_i(pop),
    .out_data_o(head_data)
  );

  // Event count tracks both stages; a flush empties everything at once.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || wr_queue) begin
      count_r <= TRF_COUNT_RESET;
    end else begin
      count_r <= count_r + {4'h0, push} - {4'h0, pop};
    end
  end

  // Overflow is sticky until a flush; an event lost in the flush cycle is
  // not an overflow because the queue is empty afterwards.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || wr_queue) begin
      ovf_r <= 1'b0;
    end else if (event_valid_i && full) begin
      ovf_r <= 1'b1;
    end
  end

  // Queue presentation. The head stage can lag one cycle behind the count
  // after a push, so "more" uses the count, which is exact.
  logic q_empty;
  logic [7:0] queue_word;
  assign q_empty = (count_r == TRF_COUNT_RESET) || !head_valid;
  always_comb begin
    queue_word = 8'h00;
    queue_word[TRF_Q_EMPTY_BIT] = q_empty;
    queue_word[TRF_Q_OVF_BIT] = ovf_r;
    if (!q_empty) begin
      queue_word[TRF_Q_MORE_BIT] = (count_r > 5'h01);
      queue_word[TRF_Q_TOUCH_BIT] = head_data[4];
      queue_word[3:0] = head_data[3:0];
    end
  end

  // Fault code: first short seen is held; ground wins a tie in scan order.
  // A short that lands in the same cycle as a clearing write wins, so the fresh fault
  // keeps its code, but that write still clears fault_irq_o and no new one is raised.
  trf_fault_type fault_r;
  logic fault_open;
  assign fault_open = (fault_r == TRF_FAULT_NONE) || (wr_fault && stop_mode);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fault_r <= TRF_FAULT_NONE;
    end else if (fault_open && short_gnd_i) begin
      fault_r <= TRF_FAULT_GND;
    end else if (fault_open && short_supply_i) begin
      fault_r <= TRF_FAULT_SUPPLY;
    end else if (wr_fault && stop_mode) begin
      fault_r <= TRF_FAULT_NONE;
    end
  end

  // A standing short halts the scan engine.
  assign scan_allow_o = (fault_r == TRF_FAULT_NONE);

  // Read data is registered so it is stable for the whole I2C byte.
  logic [7:0] rdata_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        TRF_ADDR_QUEUE: rdata_r <= queue_word;
        TRF_ADDR_FAULT: rdata_r <= {3'b000, limit_r, 2'b00, fault_r};
        TRF_ADDR_LIVE: rdata_r <= live_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end
  assign reg_rdata_o = rdata_r;

  // Data interrupt: armed only after the queue has been empty; set wins
  // over a clear in the same cycle.
  logic was_empty_r;
  logic armed_r;
  logic data_irq_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      was_empty_r <= 1'b1;
      armed_r <= 1'b1;
      data_irq_r <= 1'b0;
    end else begin
      was_empty_r <= q_empty;
      if (q_empty) begin
        armed_r <= 1'b1;
      end
      if (was_empty_r && !q_empty && armed_r) begin
        data_irq_r <= 1'b1;
        armed_r <= 1'b0;
      end else if (rd_queue || wr_queue) begin
        data_irq_r <= 1'b0;
      end
    end
  end
  assign data_irq_o = data_irq_r;

  // Fault interrupt follows the code leaving zero; cleared by a fault write made in stop mode.
  logic fault_prev_zero_r;
  logic fault_irq_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fault_prev_zero_r <= 1'b1;
      fault_irq_r <= 1'b0;
    end else begin
      fault_prev_zero_r <= (fault_r == TRF_FAULT_NONE);
      if (fault_prev_zero_r && fault_r != TRF_FAULT_NONE) begin
        fault_irq_r <= 1'b1;
      end else if (wr_fault && stop_mode) begin
        fault_irq_r <= 1'b0;
      end
    end
  end
  assign fault_irq_o = fault_irq_r;

endmodule // trf_report
`default_nettype wire

// file: verilog/trf_pkg.sv
// Package for the touch reporting block: register offsets, field positions,
// reset values and queue sizing shared by the design files.
// Assumes an I2C slave front end that turns bus cycles into register strobes.
package trf_pkg;

  // Register offsets on the I2C register port.
  localparam logic [7:0] TRF_ADDR_QUEUE = 8'h00;
  localparam logic [7:0] TRF_ADDR_FAULT = 8'h01;
  localparam logic [7:0] TRF_ADDR_LIVE = 8'h02;

  // Event queue field positions.
  localparam int TRF_Q_MORE_BIT = 7;
  localparam int TRF_Q_EMPTY_BIT = 6;
  localparam int TRF_Q_OVF_BIT = 5;
  localparam int TRF_Q_TOUCH_BIT = 4;

  // Fault register field positions.
  localparam int TRF_F_LIMIT_BIT = 4;

  // Fault codes held in bits 1:0 of the fault register.
  typedef enum logic [1:0] {
    TRF_FAULT_NONE = 2'b00,
    TRF_FAULT_GND = 2'b01,
    TRF_FAULT_SUPPLY = 2'b10
  } trf_fault_type;

  // Queue sizing: the device holds 30 events; the FIFO module carries 16-word
  // stages, so two stages are chained behind the occupancy counter.
  localparam int TRF_QUEUE_DEPTH = 30;
  localparam int TRF_EVENT_WIDTH = 5;
  localparam int TRF_FIFO_DEPTH = 16;
  localparam int TRF_NUM_ELECTRODES = 8;

  // Reset values.
  localparam logic [4:0] TRF_COUNT_RESET = 5'h00;
  localparam logic [7:0] TRF_LIVE_RESET = 8'h00;

endpackage : trf_pkg

// file: verilog/trf_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset; flush empties it.
`timescale 1ns/1ps
`default_nettype none
module trf_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // Fill side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // Storage is an array of flip-flops addressed by pointers.
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Full and empty come straight from the count, so they are never stale.
  assign in_ready_o = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rd_ptr_r];

  // Writes into storage; data is not reset because the count guards it.
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointer and count bookkeeping.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // trf_fifo
`default_nettype wire

// file: dv/trf_report_asserts.sv
// Checker for the touch reporting block, bound to its top module.
// Sees only the top module's ports; one clock with a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module trf_report_asserts (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port and mode bits.
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic scan_enable_bit_i,
  input wire logic duty_cycle_disable_bit_i,
  // Scan engine side and trigger outputs.
  input wire logic [7:0] touched_i,
  input wire logic short_gnd_i,
  input wire logic short_supply_i,
  input wire logic scan_allow_o,
  input wire logic data_irq_o,
  input wire logic fault_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Lowest touched pad, the only one the live register may show.
  wire logic [7:0] lowest;
  assign lowest = touched_i & (~touched_i + 8'h01);
  a_live_lowest: assert property (reg_rd_i && reg_addr_i == 8'h02 |=>
    reg_rdata_o == $past(lowest, 2)) else $error("live status wrong");
  a_queue_flags: assert property (reg_rd_i && reg_addr_i == 8'h00 |=>
    !(reg_rdata_o[7] && reg_rdata_o[6]) && !reg_rdata_o[3] &&
    (!reg_rdata_o[6] || reg_rdata_o[4:0] == 5'h00)) else $error("queue flags wrong");
  a_short_halt: assert property (short_gnd_i |=> !scan_allow_o)
    else $error("scan not halted");
  // A fault may only go away through a write made in stop mode.
  a_fault_hold: assert property (!scan_allow_o && !(reg_wr_i && reg_addr_i == 8'h01 &&
    !scan_enable_bit_i && duty_cycle_disable_bit_i) |=> !scan_allow_o)
    else $error("fault cleared");
  a_clear_stop: assert property (reg_wr_i && reg_addr_i == 8'h01 && !scan_enable_bit_i &&
    duty_cycle_disable_bit_i && !short_gnd_i && !short_supply_i |=> scan_allow_o)
    else $error("fault not cleared");
  a_fault_code: assert property (reg_rd_i && reg_addr_i == 8'h01 |=>
    reg_rdata_o[1:0] != 2'b11 && reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[3:2] == 2'h0 &&
    ((reg_rdata_o[1:0] == 2'b00) == $past(scan_allow_o))) else $error("fault code wrong");
  a_fault_irq: assert property ($rose(fault_irq_o) |-> !scan_allow_o)
    else $error("fault trigger without fault");
  a_data_irq_clr: assert property (data_irq_o && reg_rd_i && reg_addr_i == 8'h00
    |=> !data_irq_o) else $error("data trigger not cleared");
endmodule // trf_report_asserts
bind trf_report trf_report_asserts chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o), .scan_enable_bit_i(scan_enable_bit_i),
  .duty_cycle_disable_bit_i(duty_cycle_disable_bit_i), .touched_i(touched_i),
  .short_gnd_i(short_gnd_i), .short_supply_i(short_supply_i),
  .scan_allow_o(scan_allow_o), .data_irq_o(data_irq_o), .fault_irq_o(fault_irq_o));
`default_nettype wire

// file: dv/trf_host_model.sv
// Host side model: register reads and writes as one-cycle strobes.
// Assumes the bench calls its tasks; it owns the register port alone.
`timescale 1ns/1ps
`default_nettype none
module trf_host_model (
  // Clock.
  input wire logic sys_clk_i,
  // Register port.
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  input wire logic [7:0] reg_rdata_i
);
  // Idle port at time zero.
  initial begin
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'hFF;
  end
  // The trailing edges keep pops apart so the head stage can refill.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a; // A released address never repeats the last one.
    @(posedge sys_clk_i);
    #1 d = reg_rdata_i;
    @(posedge sys_clk_i);
  endtask
  // Writes carry no data; they only flush the queue or clear a fault.
  task automatic wr(input logic [7:0] a);
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge sys_clk_i);
  endtask
endmodule // trf_host_model
`default_nettype wire

// file: dv/test_touch_report_fifo_fault.sv
// Self-checking bench for the touch reporting block with a queue model.
// Assumes the host model drives the register port; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module test_touch_report_fifo_fault;
  import trf_pkg::*;
  // Signals around the block.
  logic clk, rst, rd, wr, scan, duty, ev_v, ev_t, sg, ss, allow, dirq, firq;
  logic [7:0] addr, rdata, touched, d;
  logic [3:0] maxc;
  logic [2:0] ev_e;
  // Queue model holding {touch, 0, index}, counters and random state.
  int failures, compares, cyc;
  int q[$];
  logic ovf;
  logic [31:0] lfsr;
  trf_report dut_u (.sys_clk_i(clk), .rst_i(rst), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_rdata_o(rdata), .scan_enable_bit_i(scan),
    .duty_cycle_disable_bit_i(duty), .max_touch_count_setting_i(maxc),
    .touched_i(touched), .event_valid_i(ev_v), .event_touch_i(ev_t),
    .event_electrode_i(ev_e), .short_gnd_i(sg), .short_supply_i(ss),
    .scan_allow_o(allow), .data_irq_o(dirq), .fault_irq_o(firq));
  trf_host_model host_u (.sys_clk_i(clk), .reg_rd_o(rd), .reg_wr_o(wr),
    .reg_addr_o(addr), .reg_rdata_i(rdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The run needs about 550 cycles, so this only fires on a hang.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One event pulse; the model drops it once thirty are held.
  task automatic ev(input logic t, input logic [2:0] e);
    @(posedge clk);
    ev_v <= 1'b1;
    ev_t <= t;
    ev_e <= e;
    @(posedge clk);
    ev_v <= 1'b0;
    if (q.size() < 30) q.push_back({t, 1'b0, e});
    else ovf = 1'b1;
  endtask
  // Reads the queue register and checks it against the model head.
  task automatic pop();
    logic [7:0] e;
    e = {2'b01, ovf, 5'h00};
    if (q.size() > 0) e = {q.size() > 1, 1'b0, ovf, q[0][4:0]};
    host_u.rd(TRF_ADDR_QUEUE, d);
    chk("queue", e, d);
    if (q.size() > 0) void'(q.pop_front());
  endtask
  initial begin
    rst = 1'b1;
    {ev_v, ev_t, sg, ss, scan, duty} = 6'h00;
    {touched, maxc, ev_e, ovf} = 16'h0000;
    lfsr = 32'h720B;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    pop();
    // Single pads first, then random patterns against random limits.
    for (int i = 0; i < 24; i++) begin
      lfsr = step(lfsr);
      @(posedge clk);
      touched <= (i < 8) ? (8'h01 << i) : lfsr[7:0];
      maxc <= {1'b0, lfsr[10:8]};
      repeat (2) @(posedge clk);
      host_u.rd(TRF_ADDR_LIVE, d);
      chk("live", touched & (~touched + 8'h01), d);
      host_u.rd(TRF_ADDR_FAULT, d);
      chk("limit", {3'h0, $countones(touched) > maxc, 4'h0}, d);
    end
    touched <= 8'h00;
    ev(1'b1, 3'h7);
    repeat (4) @(posedge clk);
    #1 chk("data irq", 8'h01, {7'h00, dirq});
    // Thirty more events overfill the queue by one.
    for (int i = 0; i < 30; i++) begin
      lfsr = step(lfsr);
      ev(lfsr[0], lfsr[3:1]);
    end
    repeat (4) @(posedge clk);
    for (int i = 0; i < 32; i++) begin
      pop();
      if (i == 0) chk("data irq", 8'h00, {7'h00, dirq});
    end
    // A write flushes pending events and the overflow mark.
    for (int i = 0; i < 3; i++) ev(1'b0, i[2:0]);
    repeat (4) @(posedge clk);
    #1 chk("data irq", 8'h01, {7'h00, dirq});
    host_u.wr(TRF_ADDR_QUEUE);
    chk("data irq", 8'h00, {7'h00, dirq});
    q.delete();
    ovf = 1'b0;
    pop();
    host_u.rd(8'h03, d);
    chk("unmapped", 8'h00, d);
    // Each short kind first, then both at once, which must not change the code.
    for (int k = 0; k < 2; k++) begin
      scan <= 1'b1;
      duty <= 1'b0;
      @(posedge clk);
      ss <= (k == 0);
      sg <= (k == 1);
      @(posedge clk);
      {ss, sg} <= 2'b11;
      @(posedge clk);
      {ss, sg} <= 2'b00;
      repeat (2) @(posedge clk);
      #1 chk("halt", 8'h01, {6'h00, allow, firq});
      host_u.wr(TRF_ADDR_FAULT);
      host_u.rd(TRF_ADDR_FAULT, d);
      chk("fault", (k == 0) ? 8'h02 : 8'h01, d);
      scan <= 1'b0;
      duty <= 1'b1;
      host_u.wr(TRF_ADDR_FAULT);
      host_u.rd(TRF_ADDR_FAULT, d);
      chk("cleared", 8'h00, d);
      chk("resume", 8'h02, {6'h00, allow, firq});
    end
    give_verdict();
  end
endmodule // test_touch_report_fifo_fault
`default_nettype wire
